// file: rtl/pse_event_summary_consts.vh
`ifndef PSE_EVENT_SUMMARY_CONSTS_VH
`define PSE_EVENT_SUMMARY_CONSTS_VH

// ==========================================
// Register command codes
`define ADDR_SUMMARY 8'h00
`define ADDR_MASK 8'h01
`define ADDR_GEN_MASK 8'h7E
`define ADDR_RESET_CMD 8'h7F

// ==========================================
// Reset values
`define SUMMARY_RST 8'h80
`define MASK_RST 8'h80
`define GLOBAL_IRQ_ENABLE_RST 1'h0
`define RDATA_RST 8'h00
`define IRQ_N_RST 1'b1

// ==========================================
// Summary bit positions
`define BIT_SUPPLY 7
`define BIT_START 6
`define BIT_OVERCURRENT 5
`define BIT_CLASS 4
`define BIT_DETECT 3
`define BIT_DISCONNECT 2
`define BIT_PGOOD 1
`define BIT_PENABLE 0

// ==========================================
// Control bit positions
`define GEN_GLOBAL_IRQ_ENABLE_BIT 7
`define RESET_CLR_BIT 7

`endif

// file: rtl/pse_event_summary_flags.v
`timescale 1ns/1ps
`include "pse_event_summary_consts.vh"

// Behaviour
// - Bit 7 ORs thermal, supply and memory faults, resets 1
// - Bit 6 ORs channel start faults
// - Bit 5 ORs overload cut and current limit
// - Bit 4 ORs classification done flags
// - Bit 3 ORs detection done flags
// - Bit 2 ORs disconnect flags
// - Bit 1 ORs power good change flags
// - Bit 0 ORs power enable change flags
// - Event read or reset bit clears
// - Masked set bit with enable drives interrupt low
// - Mask bit zero blocks that interrupt
// - Summary updates regardless of mask
module pse_event_summary_flags #(
    parameter CHANNELS = 4,
    parameter DATA_WIDTH = 8
)
(
    input wire core_clk_i,
    input wire rst_i,
    input wire thermal_shutdown_flag_i,
    input wire digital_supply_uv_flag_i,
    input wire digital_supply_warn_flag_i,
    input wire power_supply_uv_flag_i,
    input wire memory_fault_flag_i,
    input wire [CHANNELS-1:0] chan_start_fault_i,
    input wire [CHANNELS-1:0] chan_overload_cut_i,
    input wire [CHANNELS-1:0] chan_current_limit_i,
    input wire [CHANNELS-1:0] chan_class_done_i,
    input wire [CHANNELS-1:0] chan_detect_done_i,
    input wire [CHANNELS-1:0] chan_disconnect_i,
    input wire [CHANNELS-1:0] chan_power_good_change_i,
    input wire [CHANNELS-1:0] chan_power_enable_change_i,
    input wire [DATA_WIDTH-1:0] event_reg_read_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [DATA_WIDTH-1:0] reg_wdata_i,
    output reg [DATA_WIDTH-1:0] reg_rdata_o,
    output reg irq_n_o
);

    // ==========================================
    // Helpers
    function any_set;
        input [CHANNELS-1:0] flags;
        begin
            any_set = |flags;
        end
    endfunction

    function addr_hit;
        input [7:0] addr;
        input [7:0] code;
        begin
            addr_hit = (addr == code);
        end
    endfunction

    // ==========================================
    // State
    reg [DATA_WIDTH-1:0] event_summary_flags;
    reg [DATA_WIDTH-1:0] irq_mask;
    reg global_irq_enable;

    reg [DATA_WIDTH-1:0] next_event_summary_flags;
    reg [DATA_WIDTH-1:0] next_irq_mask;
    reg next_global_irq_enable;
    reg [DATA_WIDTH-1:0] next_reg_rdata;
    reg next_irq_n;

    reg [DATA_WIDTH-1:0] set_vec;
    reg [DATA_WIDTH-1:0] clr_vec;
    reg summary_clear_all;

    wire supply_fault_summary;
    wire start_fault_summary;
    wire overcurrent_fault_summary;
    wire class_done_summary;
    wire detect_done_summary;
    wire disconnect_summary;
    wire power_good_change_summary;
    wire power_enable_change_summary;

    // ==========================================
    // Source reduction
    assign supply_fault_summary = thermal_shutdown_flag_i | digital_supply_uv_flag_i
        | digital_supply_warn_flag_i | power_supply_uv_flag_i | memory_fault_flag_i;
    assign start_fault_summary = any_set(chan_start_fault_i);
    assign overcurrent_fault_summary = any_set(chan_overload_cut_i)
        | any_set(chan_current_limit_i);
    assign class_done_summary = any_set(chan_class_done_i);
    assign detect_done_summary = any_set(chan_detect_done_i);
    assign disconnect_summary = any_set(chan_disconnect_i);
    assign power_good_change_summary = any_set(chan_power_good_change_i);
    assign power_enable_change_summary = any_set(chan_power_enable_change_i);

    // ==========================================
    // Set vector
    always @*
    begin
        set_vec = {DATA_WIDTH{1'b0}};
        set_vec[`BIT_SUPPLY] = supply_fault_summary;
        set_vec[`BIT_START] = start_fault_summary;
        set_vec[`BIT_OVERCURRENT] = overcurrent_fault_summary;
        set_vec[`BIT_CLASS] = class_done_summary;
        set_vec[`BIT_DETECT] = detect_done_summary;
        set_vec[`BIT_DISCONNECT] = disconnect_summary;
        set_vec[`BIT_PGOOD] = power_good_change_summary;
        set_vec[`BIT_PENABLE] = power_enable_change_summary;
    end

    // ==========================================
    // Clear vector
    always @*
    begin
        summary_clear_all = reg_wr_i & addr_hit(reg_addr_i, `ADDR_RESET_CMD)
            & reg_wdata_i[`RESET_CLR_BIT];
        if (summary_clear_all)
        begin
            clr_vec = {DATA_WIDTH{1'b1}};
        end
        else
        begin
            clr_vec = event_reg_read_i;
        end
    end

    // ==========================================
    // Summary update, set wins over clear
    always @*
    begin
        next_event_summary_flags = (event_summary_flags & ~clr_vec) | set_vec;
    end

    // ==========================================
    // Register writes
    always @*
    begin
        next_irq_mask = irq_mask;
        next_global_irq_enable = global_irq_enable;
        if (reg_wr_i)
        begin
            if (addr_hit(reg_addr_i, `ADDR_MASK))
            begin
                next_irq_mask = reg_wdata_i;
            end
            else if (addr_hit(reg_addr_i, `ADDR_GEN_MASK))
            begin
                next_global_irq_enable = reg_wdata_i[`GEN_GLOBAL_IRQ_ENABLE_BIT];
            end
            else
            begin
                next_irq_mask = irq_mask;
            end
        end
    end

    // ==========================================
    // Register reads
    always @*
    begin
        next_reg_rdata = reg_rdata_o;
        if (reg_rd_i)
        begin
            if (addr_hit(reg_addr_i, `ADDR_SUMMARY))
            begin
                next_reg_rdata = event_summary_flags;
            end
            else if (addr_hit(reg_addr_i, `ADDR_MASK))
            begin
                next_reg_rdata = irq_mask;
            end
            else if (addr_hit(reg_addr_i, `ADDR_GEN_MASK))
            begin
                next_reg_rdata = {DATA_WIDTH{1'b0}};
                next_reg_rdata[`GEN_GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable;
            end
            else if (addr_hit(reg_addr_i, `ADDR_RESET_CMD))
            begin
                next_reg_rdata = {DATA_WIDTH{1'b0}};
            end
            else
            begin
                next_reg_rdata = {DATA_WIDTH{1'b0}};
            end
        end
    end

    // ==========================================
    // Interrupt pin
    always @*
    begin
        next_irq_n = ~(global_irq_enable & (|(event_summary_flags & irq_mask)));
    end

    // ==========================================
    // Flip-flops
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            event_summary_flags <= `SUMMARY_RST;
            irq_mask <= `MASK_RST;
            global_irq_enable <= `GLOBAL_IRQ_ENABLE_RST;
            reg_rdata_o <= `RDATA_RST;
            irq_n_o <= `IRQ_N_RST;
        end
        else
        begin
            event_summary_flags <= next_event_summary_flags;
            irq_mask <= next_irq_mask;
            global_irq_enable <= next_global_irq_enable;
            reg_rdata_o <= next_reg_rdata;
            irq_n_o <= next_irq_n;
        end
    end

endmodule

// file: dv/pse_event_summary_chk.sv
`timescale 1ns/1ps
// ==========================================
// Summary bit and pin checks
module pse_event_summary_chk #(
    parameter CHANNELS = 4
)
(
    input wire core_clk_i,
    input wire rst_i,
    input wire [CHANNELS-1:0] chan_start_fault_i,
    input wire [CHANNELS-1:0] chan_overload_cut_i,
    input wire [CHANNELS-1:0] chan_current_limit_i,
    input wire [CHANNELS-1:0] chan_class_done_i,
    input wire [CHANNELS-1:0] chan_detect_done_i,
    input wire [CHANNELS-1:0] chan_disconnect_i,
    input wire [CHANNELS-1:0] chan_power_good_change_i,
    input wire [CHANNELS-1:0] chan_power_enable_change_i,
    input wire [7:0] reg_addr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire irq_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire rd0 = reg_rd_i && reg_addr_i == 8'h00;
    property p_rst; disable iff (1'b0) rst_i |=> irq_n_o && reg_rdata_o == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs wrong");
    property p_start; (|chan_start_fault_i) ##1 rd0 |=> reg_rdata_o[6]; endproperty
    a_start: assert property (p_start) else $error("start bit missing");
    property p_ovl; (|(chan_overload_cut_i | chan_current_limit_i)) ##1 rd0 |=> reg_rdata_o[5]; endproperty
    a_ovl: assert property (p_ovl) else $error("overcurrent bit missing");
    property p_cls; (|chan_class_done_i) ##1 rd0 |=> reg_rdata_o[4]; endproperty
    a_cls: assert property (p_cls) else $error("class bit missing");
    property p_det; (|chan_detect_done_i) ##1 rd0 |=> reg_rdata_o[3]; endproperty
    a_det: assert property (p_det) else $error("detect bit missing");
    property p_dis; (|chan_disconnect_i) ##1 rd0 |=> reg_rdata_o[2]; endproperty
    a_dis: assert property (p_dis) else $error("disconnect bit missing");
    property p_pg; (|chan_power_good_change_i) ##1 rd0 |=> reg_rdata_o[1]; endproperty
    a_pg: assert property (p_pg) else $error("power good bit missing");
    property p_pe; (|chan_power_enable_change_i) ##1 rd0 |=> reg_rdata_o[0]; endproperty
    a_pe: assert property (p_pe) else $error("power enable bit missing");
endmodule
bind pse_event_summary_flags pse_event_summary_chk #(.CHANNELS(CHANNELS)) u_chk (.*);

// file: dv/host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host register access
module host_model
(
    input wire core_clk_i,
    input wire [7:0] rdata_i,
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic [7:0] evt_rd_o = 8'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0
);
    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk_i) #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge core_clk_i) #1;
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i) #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge core_clk_i) #1;
        rd_o = 1'b0;
        d = rdata_i;
    endtask
    task automatic clr(input logic [7:0] b);
        @(posedge core_clk_i) #1;
        evt_rd_o = b;
        @(posedge core_clk_i) #1;
        evt_rd_o = 8'h00;
    endtask
endmodule

// file: dv/test_pse_event_summary_flags.sv
`timescale 1ns/1ps
// ==========================================
// Bench
module test_pse_event_summary_flags;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [36:0] src = '0;
    logic [7:0] addr, wdata, evt, rdata, v;
    logic wr, rd;
    wire irq_n;
    int fail_count = 0;
    int check_count = 0;
    always #2.5 core_clk = ~core_clk;
    pse_event_summary_flags u_dut (.core_clk_i(core_clk), .rst_i(rst), .thermal_shutdown_flag_i(src[0]),
        .digital_supply_uv_flag_i(src[1]), .digital_supply_warn_flag_i(src[2]), .power_supply_uv_flag_i(src[3]),
        .memory_fault_flag_i(src[4]), .chan_start_fault_i(src[8:5]), .chan_overload_cut_i(src[12:9]),
        .chan_current_limit_i(src[16:13]), .chan_class_done_i(src[20:17]), .chan_detect_done_i(src[24:21]),
        .chan_disconnect_i(src[28:25]), .chan_power_good_change_i(src[32:29]),
        .chan_power_enable_change_i(src[36:33]), .event_reg_read_i(evt), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .irq_n_o(irq_n));
    host_model u_host (.core_clk_i(core_clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .evt_rd_o(evt), .wr_o(wr), .rd_o(rd));
    task automatic chk(input string name, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic reset_values;
        u_host.rd(8'h00, v);
        chk("summary", 8'h80, v);
        u_host.rd(8'h01, v);
        chk("mask", 8'h80, v);
        chk("irq", 8'h01, {7'h00, irq_n});
        u_host.wr(8'h7F, 8'h80);
        u_host.rd(8'h00, v);
        chk("summary", 8'h00, v);
    endtask
    task automatic each_source;
        int b;
        for (int i = 0; i < 37; i++)
        begin
            b = i < 5 ? 7 : i < 9 ? 6 : i < 17 ? 5 : 4 - (i - 17) / 4;
            src[i] = 1'b1;
            u_host.rd(8'h00, v);
            src = '0;
            chk("summary", 8'h01 << b, v);
            u_host.clr(8'h01 << b);
            u_host.rd(8'h00, v);
            chk("cleared", 8'h00, v);
        end
    endtask
    task automatic set_wins;
        src[33] = 1'b1;
        u_host.clr(8'h01);
        u_host.rd(8'h00, v);
        chk("set wins", 8'h01, v);
        src = '0;
        u_host.clr(8'h01);
        u_host.rd(8'h00, v);
        chk("cleared", 8'h00, v);
    endtask
    task automatic masked_irq;
        u_host.wr(8'h7E, 8'h80);
        u_host.rd(8'h7E, v);
        chk("enable", 8'h80, v);
        u_host.wr(8'h01, 8'h04);
        u_host.rd(8'h01, v);
        chk("mask", 8'h04, v);
        src[25] = 1'b1;
        u_host.rd(8'h00, v);
        src = '0;
        chk("summary", 8'h04, v);
        chk("irq", 8'h00, {7'h00, irq_n});
        u_host.wr(8'h00, 8'hFF);
        u_host.rd(8'h00, v);
        chk("read only", 8'h04, v);
        u_host.wr(8'h7F, 8'h80);
        src[29] = 1'b1;
        u_host.rd(8'h00, v);
        src = '0;
        chk("summary", 8'h02, v);
        chk("irq", 8'h01, {7'h00, irq_n});
        u_host.rd(8'h55, v);
        chk("unmapped", 8'h00, v);
        u_host.rd(8'h7F, v);
        chk("reset cmd", 8'h00, v);
    endtask
    task automatic mid_reset;
        src[25] = 1'b1;
        u_host.rd(8'h00, v);
        src = '0;
        chk("irq", 8'h00, {7'h00, irq_n});
        @(posedge core_clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        u_host.rd(8'h00, v);
        chk("summary", 8'h80, v);
        u_host.rd(8'h01, v);
        chk("mask", 8'h80, v);
        u_host.rd(8'h7E, v);
        chk("enable", 8'h00, v);
        chk("irq", 8'h01, {7'h00, irq_n});
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        reset_values();
        each_source();
        set_wins();
        masked_irq();
        mid_reset();
        complete_run();
    end
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end
endmodule
